// >>> include/onoff_pkg.sv
// Package with constants and carriers for the on/off cycle controller
package onoff_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ = 40000000;
	localparam int unsigned RATE_LOW_HZ = 44000;
	localparam int unsigned RATE_HIGH_HZ = 130000;
	localparam int unsigned MAX_ON_PCT = 67;
	localparam int unsigned PCT_FULL = 100;
	localparam int unsigned BLANK_NS = 200;
	localparam int unsigned CLK_PERIOD_NS = 25;
	localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Cycle lengths in clocks (longest time rounds down)
	localparam int unsigned PERIOD_LOW_CYC = CLK_HZ / RATE_LOW_HZ;
	localparam int unsigned PERIOD_HIGH_CYC = CLK_HZ / RATE_HIGH_HZ;
	localparam int CNT_W = 11;
	localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
	localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;

	// Controller states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_ON = 3'b010,
		ST_OFF = 3'b100
	} phase_e;

	// Status inputs from the analog side
	typedef struct packed {
		logic feedback_gate;
		logic current_limit;
		logic over_temp;
		logic supply_ok;
	} sense_s;

	// Outputs toward the switch and observers
	typedef struct packed {
		logic switch_on;
		logic cycle_start;
		logic max_on_active;
		logic skipping;
	} drive_s;
endpackage : onoff_pkg

// >>> hdl/cycle_osc.sv
// Free-running oscillator producing cycle starts and the max-on window
`timescale 1ns/1ps
`default_nettype none
module cycle_osc
	import onoff_pkg::*;
#(
	parameter bit HIGH_RATE = 1'b0
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Control
	input wire logic skip_fast_i,
	// Timing outputs
	output logic start_o,
	output logic max_on_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} osc_s;

	localparam logic [CNT_W-1:0] PER_FULL =
		CNT_W'(HIGH_RATE ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC);
	localparam logic [CNT_W-1:0] ON_FULL = CNT_W'((int'(PER_FULL) * MAX_ON_PCT) / PCT_FULL);

	osc_s st_q;
	osc_s st_d;
	logic [CNT_W-1:0] per;
	logic [CNT_W-1:0] on_len;

	// Doubled rate while skipping on the low-rate build only
	always_comb
	begin
		per = (skip_fast_i && !HIGH_RATE) ? (PER_FULL >> 1) : PER_FULL;
		on_len = (skip_fast_i && !HIGH_RATE) ? (ON_FULL >> 1) : ON_FULL;
		st_d = st_q;
		// Never halts, so cycle starts keep coming even when skipping
		if (st_q.cnt >= per - CNT_ONE)
			st_d.cnt = CNT_ZERO;
		else
			st_d.cnt = st_q.cnt + CNT_ONE;
		start_o = (st_q.cnt == CNT_ZERO);
		max_on_o = (st_q.cnt < on_len);
	end

	// State register
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end
endmodule // cycle_osc
`default_nettype wire

// >>> hdl/onoff_switch_ctrl.sv
// Top of the on/off cycle-skipping switch controller
// Summary of operation
// - Feedback gate sampled once at each cycle start; that sample decides.
// - A started switching cycle always completes regardless of feedback changes.
// - High sample switches the cycle; low sample skips and resamples next start.
// - Oscillator runs continuously, switching or skipping.
// - On-pulse ends when current limit is reached.
// - With supply too low the switch stays off, no glitches.
// - Max-on window about 67 percent; on-pulse ends by its end.
// - Skipping doubles the rate on 44 kHz builds; 130 kHz unchanged.
// - Current limit ignored for a blanking interval after turn-on.
// - Over-temperature disables switching until it clears.
`timescale 1ns/1ps
`default_nettype none
module onoff_switch_ctrl
	import onoff_pkg::*;
#(
	parameter bit HIGH_RATE = 1'b0,
	parameter int unsigned BLANK_CYCLES = BLANK_CYC
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Sense inputs
	input wire onoff_pkg::sense_s sense_i,
	// Drive outputs
	output onoff_pkg::drive_s drive_o
);
	import onoff_pkg::*;

	typedef struct packed {
		phase_e phase;
		logic [CNT_W-1:0] blank;
		logic skipped;
		drive_s drv;
	} ctrl_s;

	localparam logic [CNT_W-1:0] BLANK_LEN = CNT_W'(BLANK_CYCLES);

	ctrl_s st_q;
	ctrl_s st_d;
	logic start;
	logic max_on;
	logic allow;

	// Oscillator; rate doubles during skipped cycles on the low-rate build only
	cycle_osc #(
		.HIGH_RATE(HIGH_RATE)
	) u_osc (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.skip_fast_i(st_q.skipped),
		.start_o(start),
		.max_on_o(max_on)
	);

	// Next-state logic
	always_comb
	begin
		st_d = st_q;
		// Low supply or hot die gates turn-on and forces off mid-pulse
		allow = sense_i.supply_ok && !sense_i.over_temp;
		st_d.drv.cycle_start = start;
		st_d.drv.max_on_active = max_on;
		case (st_q.phase)
			ST_IDLE, ST_OFF:
			begin
				st_d.drv.switch_on = 1'b0;
				if (start)
				begin
					// Only this one sample of the gate counts for the cycle
					if (sense_i.feedback_gate && allow)
					begin
						st_d.phase = ST_ON;
						st_d.drv.switch_on = 1'b1;
						st_d.blank = BLANK_LEN;
						st_d.skipped = 1'b0;
					end
					else
					begin
						st_d.phase = ST_OFF;
						st_d.skipped = sense_i.feedback_gate ? 1'b0 : 1'b1;
					end
				end
			end
			ST_ON:
			begin
				// Gate input not looked at here: cycle runs to its end
				if (st_q.blank != CNT_ZERO)
					st_d.blank = st_q.blank - CNT_ONE;
				if (!allow)
				begin
					st_d.phase = ST_OFF;
					st_d.drv.switch_on = 1'b0;
				end
				else if (sense_i.current_limit && st_q.blank == CNT_ZERO)
				begin
					st_d.phase = ST_OFF;
					st_d.drv.switch_on = 1'b0;
				end
				else if (!max_on)
				begin
					st_d.phase = ST_OFF;
					st_d.drv.switch_on = 1'b0;
				end
			end
			default:
			begin
				st_d.phase = ST_IDLE;
				st_d.drv.switch_on = 1'b0;
			end
		endcase
		st_d.drv.skipping = st_d.skipped;
	end

	// State register; switch is off from reset
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_q.phase <= ST_IDLE;
			st_q.blank <= CNT_ZERO;
			st_q.skipped <= 1'b0;
			st_q.drv <= '0;
		end
		else
			st_q <= st_d;
	end

	assign drive_o = st_q.drv;
endmodule // onoff_switch_ctrl
`default_nettype wire

// >>> verification/onoff_props_properties.sv
// Port checker for the on/off cycle controller
`timescale 1ns/1ps
`default_nettype none
module onoff_props
	import onoff_pkg::*;
#(
	parameter bit HIGH_RATE = 1'b0
)
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Watched ports
	input wire onoff_pkg::sense_s sense_i,
	input wire onoff_pkg::drive_s drive_o
);
	localparam int P = HIGH_RATE ? PERIOD_HIGH_CYC : PERIOD_LOW_CYC;
	// Short aliases
	wire logic sw = drive_o.switch_on;
	wire logic cs = drive_o.cycle_start;
	wire logic mx = drive_o.max_on_active;
	wire logic ok = sense_i.supply_ok;
	wire logic ot = sense_i.over_temp;
	logic [11:0] cnt_q;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Clocks since the last start; the first start is skipped by the guard
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
		if (!arst_n_i)
			cnt_q <= 12'h000;
		else
			cnt_q <= cs ? 12'h000 : cnt_q + 12'h001;
	sequence blank_hold;
		(sw || $past(ot) || !$past(ok)) [*8];
	endsequence
	start_only_a: assert property ($rose(sw) |-> cs) else $error("switch rose off start");
	skip_low_a: assert property (cs && !$past(sense_i.feedback_gate) |-> !sw)
		else $error("switched on low gate");
	run_high_a: assert property (cs && $past(sense_i.feedback_gate) && $past(ok) && !$past(ot)
		|-> sw) else $error("enabled cycle skipped");
	blank_a: assert property ($rose(sw) |-> blank_hold) else $error("pulse cut in blanking");
	fall_cause_a: assert property ($fell(sw) |-> $past(sense_i.current_limit) || $past(ot)
		|| !$past(ok) || !$past(mx) || !mx) else $error("pulse ended early");
	max_on_a: assert property (sw |-> mx || $past(mx)) else $error("on past max window");
	skip_flag_a: assert property (cs |-> drive_o.skipping == !$past(sense_i.feedback_gate))
		else $error("skip flag wrong at start");
	guard_off_a: assert property (!$past(ok) || $past(ot) |-> !sw) else $error("on while off");
	period_a: assert property (cs && cnt_q > 12'h001 |-> cnt_q == 12'(P - 1)
		|| (!HIGH_RATE && cnt_q == 12'(P / 2 - 1))) else $error("bad period");
endmodule // onoff_props
bind onoff_switch_ctrl onoff_props #(.HIGH_RATE(HIGH_RATE)) props (.sys_clk_i(sys_clk_i),
	.arst_n_i(arst_n_i), .sense_i(sense_i), .drive_o(drive_o));
`default_nettype wire

// >>> verification/fb_model.sv
// Secondary comparator and optocoupler feeding the gate input
`timescale 1ns/1ps
`default_nettype none
module fb_model
(
	// Clock, switch and load
	input wire logic clk_i,
	input wire logic sw_i,
	input wire logic [1:0] load_i,
	// Gate toward the controller
	output logic gate_o
);
	int v_q = 0;
	int v_n;
	// Charge per on clock is large enough that long pulses force skipped cycles
	always_comb
		v_n = v_q + (sw_i ? 64 : 0) - int'(load_i);
	// Clamped so a max-on pulse cannot stall the loop past the bench's wait bound
	always_ff @(posedge clk_i)
	begin
		v_q <= v_n < 0 ? 0 : (v_n > 2047 ? 2047 : v_n);
		gate_o <= v_q < 64;
	end
endmodule // fb_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the on/off cycle controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0d got %0d", nm, e, g); end end
module tb_top;
	import onoff_pkg::*;
	logic sys_clk_i = 0, arst_n_i = 0, cl = 0, ot = 0, ok = 1;
	logic [1:0] ld = 2'h1;
	wire logic fb;
	sense_s si;
	drive_s d;
	int miscompares = 0, n_tests = 0, k, len, n;
	int n_skip = 0;
	assign si = '{fb, cl, ot, ok};
	onoff_switch_ctrl dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .sense_i(si), .drive_o(d));
	fb_model fbm (.clk_i(sys_clk_i), .sw_i(d.switch_on), .load_i(ld), .gate_o(fb));
	// 40 MHz clock
	initial
		forever #12.5 sys_clk_i = ~sys_clk_i;
	// Clocks spent in the skipping state, to prove skips were reached
	always @(posedge sys_clk_i)
		if (d.skipping === 1'b1)
			n_skip++;
	function automatic int exp_len(int k);
		return k < 9 ? 9 : k;
	endfunction
	task automatic complete_run();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Wait for the next pulse, raise the limit k clocks after its start
	task automatic pulse(input int k, output int len);
		n = 0;
		len = 0;
		while (d.switch_on !== 1'b1 && n < 2000)
		begin
			@(posedge sys_clk_i);
			n++;
		end
		if (n == 2000)
		begin
			miscompares++;
			complete_run();
		end
		while (d.switch_on === 1'b1 && len < 2000)
		begin
			len++;
			cl <= len + 1 >= k;
			@(posedge sys_clk_i);
		end
		cl <= 1'b0;
	endtask
	// Main sequence: corners first, then random limits and loads
	initial
	begin
		void'($urandom(72041));
		repeat (12) @(posedge sys_clk_i);
		arst_n_i <= 1'b1;
		for (int i = 0; i < 12; i++)
		begin
			k = i < 3 ? i * 4 + 2 : $urandom_range(20, 2);
			ld <= 2'($urandom_range(2, 1));
			pulse(k, len);
			`CHK("on_len", exp_len(k), len)
		end
		pulse(5000, len);
		`CHK("max_on", PERIOD_LOW_CYC * MAX_ON_PCT / PCT_FULL, len)
		for (int j = 0; j < 2; j++)
		begin
			ot <= j == 0;
			ok <= j == 0;
			repeat (2) @(posedge sys_clk_i);
			n = 0;
			repeat (1000) @(posedge sys_clk_i) n += d.switch_on;
			`CHK("blocked", 0, n)
			ot <= 1'b0;
			ok <= 1'b1;
			pulse(12, len);
			`CHK("resume", 12, len)
		end
		`CHK("skip_seen", 1'b1, n_skip > 0)
		complete_run();
	end
endmodule // tb_top
`default_nettype wire
